// ===== ldc_dev.sv
// Behavioural model of the display device behind the indirect bus
`timescale 1ns/10ps
module ldc_dev #(
   parameter int PITCH = 40
) (
   // Host pins
   input ldc_pkg::ldc_pins_s pins_i,
   // Data toward host
   output logic [7:0] d_o
);
   import ldc_pkg::*;
   logic [7:0] cg_lo = 8'h00;
   logic [7:0] cg_hi = 8'h00;
   logic [7:0] shift = 8'h00;
   logic [7:0] depth = 8'h00;
   logic [7:0] cmd = 8'h00;
   logic [7:0] rdv;
   logic [7:0] last = 8'h00;
   logic [15:0] cursor = 16'h0000;
   logic [1:0] dir = 2'b00;
   logic [7:0] mem [256];
   int pidx = 0;
   int ridx = 0;
   // Step after every store and fetch; scrolling never touches it
   function automatic logic [15:0] step(input logic [15:0] c);
      case (dir)
         2'b00: return c + 16'h0001;
         2'b01: return c - 16'h0001;
         2'b10: return c - 16'(PITCH);
         default: return c + 16'(PITCH);
      endcase
   endfunction
   always @(posedge pins_i.wr_n) begin
      if (!pins_i.cs_n && pins_i.a0) begin
         cmd = pins_i.d;
         pidx = 0;
         ridx = 0;
         if (pins_i.d[7:2] == 6'b0100_11) dir = pins_i.d[1:0];
      end else if (!pins_i.cs_n) begin
         case (cmd)
            CMD_CGBASE: if (pidx == 0) cg_lo = pins_i.d; else cg_hi = pins_i.d;
            CMD_SHIFT: shift = pins_i.d;
            CMD_CURSOR_SET: if (pidx == 0) cursor[7:0] = pins_i.d; else cursor[15:8] = pins_i.d;
            CMD_DEPTH: depth = pins_i.d;
            CMD_STORE: begin
               mem[cursor[7:0]] = pins_i.d;
               cursor = step(cursor);
            end
            default: ;
         endcase
         pidx++;
      end
   end
   // Cursor low byte first, then high; fetch reads at the cursor
   always @* begin
      case (cmd)
         CMD_CURSOR_GET: rdv = (ridx == 0) ? cursor[7:0] : cursor[15:8];
         CMD_FETCH: rdv = mem[cursor[7:0]];
         default: rdv = 8'h00;
      endcase
   end
   // Released bus shows inverse of last value so a stale sample is caught
   assign d_o = (!pins_i.cs_n && !pins_i.rd_n) ? rdv : ~last;
   always @(posedge pins_i.rd_n) begin
      last = rdv;
      ridx++;
      if (cmd == CMD_FETCH) cursor = step(cursor);
   end
endmodule

// ===== ldc_host.sv
// Host controller issuing drawing-control commands over the indirect bus
`timescale 1ns/10ps
module ldc_host (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Software register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output ldc_pkg::ldc_pins_s pins_o,
   output logic [31:0] rdata_o,
   // Device data bus input
   input wire logic [7:0] d_i
);
   import ldc_pkg::*;

   ldc_state_e state, next_state;
   logic [1:0] idx, next_idx, len, next_len;
   logic [3:0] cnt, next_cnt;
   logic [7:0] seq_byte [3];
   logic [7:0] next_seq_byte [3];
   ldc_xfer_e seq_kind [3];
   ldc_xfer_e next_seq_kind [3];
   logic [15:0] base, next_base, cursor, next_cursor, cur_rd, next_cur_rd;
   logic [2:0] shift, next_shift;
   logic [1:0] depth, next_depth, cfg, next_cfg;
   logic [7:0] fetch_data, next_fetch_data, char_code, next_char_code;
   logic [4:0] char_height, next_char_height;
   logic [15:0] char_adr;
   ldc_pins_s next_pins;
   logic [31:0] next_rdata;
   logic [7:0] d_meta, d_sync;
   logic idle, last_strobe;
   logic [1:0] req_depth;

   // Data input synchroniser
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         d_meta <= 8'h00;
         d_sync <= 8'h00;
      end else begin
         d_meta <= d_i;
         d_sync <= d_meta;
      end
   end

   assign idle = (state == ST_IDLE);
   assign last_strobe = (state == ST_STROBE) && (cnt == STROBE_CYC - 4'h1);
   // Host-side copy of the device pattern address
   // Operands widened first so the product never wraps at eight bits
   assign char_adr = base + (16'(char_code) * 16'(char_height));

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_len = len;
      next_cnt = cnt;
      next_seq_byte = seq_byte;
      next_seq_kind = seq_kind;
      next_base = base;
      next_cursor = cursor;
      next_cur_rd = cur_rd;
      next_shift = shift;
      next_depth = depth;
      next_cfg = cfg;
      next_fetch_data = fetch_data;
      next_char_code = char_code;
      next_char_height = char_height;
      next_rdata = 32'h0000_0000;
      req_depth = wdata_i[1:0];
      for (int i = 0; i < 3; i++) begin
         next_seq_kind[i] = XF_PWR;
      end
      if (!idle) begin
         next_seq_kind = seq_kind;
      end
      // Writes while a sequence runs are dropped; software polls busy
      if (wr_i && idle) begin
         unique case (addr_i)
            ADDR_CGBASE: begin
               next_base = wdata_i[15:0];
               next_seq_byte[0] = CMD_CGBASE;
               next_seq_byte[1] = wdata_i[7:0];
               next_seq_byte[2] = wdata_i[15:8];
               next_seq_kind[0] = XF_CMD;
               next_len = 2'd3;
               next_state = ST_SETUP;
            end
            ADDR_SHIFT: begin
               // Shift only with 1 bpp and a padded row count, else zero
               if (depth == DEPTH_1BPP && cfg[CFG_ROW_PAD]) begin
                  next_shift = wdata_i[2:0];
               end else begin
                  next_shift = 3'h0;
               end
               next_seq_byte[0] = CMD_SHIFT;
               next_seq_byte[1] = {5'h00, next_shift};
               next_seq_kind[0] = XF_CMD;
               next_len = 2'd2;
               next_state = ST_SETUP;
            end
            ADDR_CURSOR: begin
               next_cursor = wdata_i[15:0];
               next_seq_byte[0] = CMD_CURSOR_SET;
               next_seq_byte[1] = wdata_i[7:0];
               next_seq_byte[2] = wdata_i[15:8];
               next_seq_kind[0] = XF_CMD;
               next_len = 2'd3;
               next_state = ST_SETUP;
            end
            ADDR_DEPTH: begin
               if (req_depth == DEPTH_RSVD || cfg[CFG_USER_CHAR]) begin
                  req_depth = DEPTH_1BPP;
               end
               // Multi-bit depth refused while a shift is set, so shift never meets multi-bit
               if (req_depth == DEPTH_1BPP || shift == 3'h0) begin
                  next_depth = req_depth;
                  next_seq_byte[0] = CMD_DEPTH;
                  next_seq_byte[1] = {6'h00, req_depth};
                  next_seq_kind[0] = XF_CMD;
                  next_len = 2'd2;
                  next_state = ST_SETUP;
               end
            end
            ADDR_CMD: begin
               next_seq_kind[0] = XF_CMD;
               next_state = ST_SETUP;
               unique case (wdata_i[OP_LSB +: 2])
                  OP_GET: begin
                     next_seq_byte[0] = CMD_CURSOR_GET;
                     next_seq_kind[1] = XF_RD;
                     next_seq_kind[2] = XF_RD;
                     next_len = 2'd3;
                  end
                  OP_STORE: begin
                     next_seq_byte[0] = CMD_STORE;
                     next_seq_byte[1] = wdata_i[DATA_LSB +: 8];
                     next_len = 2'd2;
                  end
                  OP_FETCH: begin
                     next_seq_byte[0] = CMD_FETCH;
                     next_seq_kind[1] = XF_RD;
                     next_len = 2'd2;
                  end
                  OP_DIR: begin
                     next_seq_byte[0] = CMD_DIR_BASE | {6'h00, wdata_i[DIR_LSB +: 2]};
                     next_len = 2'd1;
                  end
               endcase
            end
            ADDR_CHAR: begin
               next_char_code = wdata_i[7:0];
               next_char_height = wdata_i[HEIGHT_LSB +: 5];
            end
            // Layer modes live elsewhere; only the two text-layer hints are kept here
            ADDR_CFG: next_cfg = wdata_i[1:0];
            default: ;
         endcase
      end
      // Pin sequencer
      unique case (state)
         ST_IDLE: next_idx = 2'd0;
         ST_SETUP: begin
            next_cnt = 4'h0;
            next_state = ST_STROBE;
         end
         ST_STROBE: begin
            next_cnt = cnt + 4'h1;
            if (last_strobe) begin
               next_state = ST_HOLD;
               if (seq_kind[idx] == XF_RD) begin
                  // Sync adds two cycles, so data is sampled mid-strobe
                  if (seq_byte[0] == CMD_CURSOR_GET) begin
                     if (idx == 2'd1) begin
                        next_cur_rd[7:0] = d_sync;
                     end else begin
                        next_cur_rd[15:8] = d_sync;
                     end
                  end else begin
                     next_fetch_data = d_sync;
                  end
               end
            end
         end
         ST_HOLD: begin
            if (idx == len - 2'd1) begin
               next_state = ST_IDLE;
            end else begin
               next_idx = idx + 2'd1;
               next_state = ST_SETUP;
            end
         end
      endcase
      // Pins follow the next state so they come straight from flops
      next_pins.cs_n = (next_state == ST_IDLE);
      next_pins.a0 = (next_seq_kind[next_idx] != XF_PWR);
      next_pins.wr_n = !(next_state == ST_STROBE && next_seq_kind[next_idx] != XF_RD);
      next_pins.rd_n = !(next_state == ST_STROBE && next_seq_kind[next_idx] == XF_RD);
      next_pins.d_oe = (next_state != ST_IDLE) && (next_seq_kind[next_idx] != XF_RD);
      next_pins.d = next_pins.d_oe ? next_seq_byte[next_idx] : 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            ADDR_CGBASE: next_rdata = {16'h0000, base};
            ADDR_SHIFT: next_rdata = {29'h0000_0000, shift};
            ADDR_DEPTH: next_rdata = {30'h0000_0000, depth};
            ADDR_STATUS: next_rdata = {31'h0000_0000, !idle};
            ADDR_CURRD: next_rdata = {16'h0000, cur_rd};
            ADDR_FETCH: next_rdata = {24'h00_0000, fetch_data};
            ADDR_CHAR: next_rdata = {19'h0000_0, char_height, char_code};
            ADDR_CHARADR: next_rdata = {16'h0000, char_adr};
            ADDR_CFG: next_rdata = {30'h0000_0000, cfg};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         idx <= 2'd0;
         len <= 2'd1;
         cnt <= 4'h0;
         for (int i = 0; i < 3; i++) begin
            seq_byte[i] <= 8'h00;
            seq_kind[i] <= XF_PWR;
         end
         base <= 16'h0000;
         cursor <= 16'h0000;
         cur_rd <= 16'h0000;
         shift <= 3'h0;
         depth <= 2'b00;
         cfg <= 2'b00;
         fetch_data <= 8'h00;
         char_code <= 8'h00;
         char_height <= 5'h00;
         pins_o <= '{cs_n: 1'b1, a0: 1'b1, wr_n: 1'b1, rd_n: 1'b1, d_oe: 1'b0, d: 8'h00};
         rdata_o <= 32'h0000_0000;
      end else begin
         state <= next_state;
         idx <= next_idx;
         len <= next_len;
         cnt <= next_cnt;
         seq_byte <= next_seq_byte;
         seq_kind <= next_seq_kind;
         base <= next_base;
         cursor <= next_cursor;
         cur_rd <= next_cur_rd;
         shift <= next_shift;
         depth <= next_depth;
         cfg <= next_cfg;
         fetch_data <= next_fetch_data;
         char_code <= next_char_code;
         char_height <= next_char_height;
         pins_o <= next_pins;
         rdata_o <= next_rdata;
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_base_cmd;
      !pins_o.cs_n && pins_o.a0 && pins_o.d == CMD_CGBASE;
   endsequence
   sequence s_hi_param;
      !pins_o.wr_n && !pins_o.a0 && idx == 2'd2 && pins_o.d == cursor[15:8];
   endsequence

   a_base_cmd_first: assert property ((wr_i && idle && addr_i == ADDR_CGBASE) |=> s_base_cmd)
      else $error("char base command byte not first");
   a_cursor_hi_sent: assert property ((wr_i && idle && addr_i == ADDR_CURSOR) |=> ##[1:30] s_hi_param)
      else $error("cursor high byte not sent");
   a_shift_param_zero: assert property ((seq_byte[0] == CMD_SHIFT && idx == 2'd1 && !pins_o.wr_n) |-> (depth == DEPTH_1BPP || pins_o.d == 8'h00))
      else $error("nonzero shift sent at multi-bit depth");
   a_depth_param_legal: assert property ((seq_byte[0] == CMD_DEPTH && idx == 2'd1 && !pins_o.wr_n) |-> (pins_o.d[1:0] != DEPTH_RSVD && (!cfg[CFG_USER_CHAR] || pins_o.d == 8'h00)))
      else $error("illegal depth parameter sent");
   a_param_a0_low: assert property ((!pins_o.wr_n && idx != 2'd0) |-> !pins_o.a0)
      else $error("parameter written with a0 high");
   a_get_reads: assert property ((seq_byte[0] == CMD_CURSOR_GET && !pins_o.rd_n) |-> (pins_o.a0 && idx != 2'd0 && !pins_o.d_oe))
      else $error("cursor read misformed");
   a_strobe_width: assert property ($fell(pins_o.wr_n) |-> (!pins_o.wr_n)[*4] ##1 pins_o.wr_n)
      else $error("write strobe width wrong");
   a_cursor_busy_hold: assert property ((wr_i && !idle) |=> $stable(cursor))
      else $error("cursor changed while busy");
endmodule

// ===== ldc_host_bench.sv
// Self-checking bench for the drawing-control host controller
`timescale 1ns/10ps
module ldc_host_bench;
   import ldc_pkg::*;
   localparam int PITCH = 40;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   ldc_pins_s pins_o;
   logic [31:0] rdata_o;
   logic [7:0] d_i;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 ref_clk_i = ~ref_clk_i;
   ldc_host i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .pins_o(pins_o), .rdata_o(rdata_o), .d_i(d_i));
   ldc_dev #(.PITCH(PITCH)) i_dev (.pins_i(pins_o), .d_o(d_i));
   task automatic report_and_stop();
      $display("Checked %0d, errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // Writes while busy are dropped, so every command waits for idle
   task automatic cmd(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] s;
      int n;
      wr(a, v);
      n = 0;
      s = 32'h0000_0001;
      while (s[0] !== 1'b0 && n < 200) begin
         rd(ADDR_STATUS, s);
         n++;
      end
      cmp({31'h0, s[0]}, 32'h0000_0000);
   endtask
   task automatic t_reset();
      logic [31:0] v;
      logic [7:0] ra [7] = '{ADDR_CGBASE, ADDR_SHIFT, ADDR_DEPTH, ADDR_CURRD, ADDR_FETCH,
         ADDR_CHARADR, 8'h3C};
      foreach (ra[i]) begin
         rd(ra[i], v);
         cmp(v, 32'h0000_0000);
      end
   endtask
   task automatic t_cgbase();
      logic [31:0] v;
      cmd(ADDR_CGBASE, 32'h0000_6000);
      cmp({16'h0, i_dev.cg_hi, i_dev.cg_lo}, 32'h0000_6000);
      cmp({24'h0, i_dev.cmd}, 32'h0000_005C);
      cmp(32'(i_dev.pidx), 32'h0000_0002);
      wr(ADDR_CHAR, 32'h0000_0880);
      rd(ADDR_CHARADR, v);
      cmp(v, 32'h0000_6400);
      wr(ADDR_CHAR, 32'h0000_10FF);
      rd(ADDR_CHARADR, v);
      cmp(v, 32'h0000_6FF0);
   endtask
   task automatic t_cursor();
      logic [31:0] v;
      logic [15:0] e;
      logic [1:0] dd;
      logic [7:0] dat;
      cmd(ADDR_CURSOR, 32'h0000_1234);
      cmp({16'h0, i_dev.cursor}, 32'h0000_1234);
      e = 16'h1234;
      for (int d = 0; d < 4; d++) begin
         dd = 2'(d);
         dat = 8'hA0 + 8'(d);
         cmd(ADDR_CMD, {22'h0, dd, 6'h00, OP_DIR});
         cmd(ADDR_CMD, {16'h0, dat, 6'h00, OP_STORE});
         cmp({24'h0, i_dev.mem[e[7:0]]}, {24'h0, dat});
         case (dd)
            2'b00: e = e + 16'h0001;
            2'b01: e = e - 16'h0001;
            2'b10: e = e - 16'(PITCH);
            default: e = e + 16'(PITCH);
         endcase
         cmp({16'h0, i_dev.cursor}, {16'h0, e});
      end
      cmd(ADDR_CMD, {30'h0, OP_GET});
      rd(ADDR_CURRD, v);
      cmp(v, 32'h0000_1234);
      cmd(ADDR_CMD, {30'h0, OP_FETCH});
      rd(ADDR_FETCH, v);
      cmp(v, 32'h0000_00A2);
      cmp({16'h0, i_dev.cursor}, 32'h0000_1234 + 32'(PITCH));
   endtask
   task automatic t_shift_depth();
      wr(ADDR_CFG, 32'h0000_0002);
      cmd(ADDR_SHIFT, 32'h0000_0007);
      cmp({24'h0, i_dev.shift}, 32'h0000_0007);
      cmd(ADDR_DEPTH, 32'h0000_0001);
      cmp({24'h0, i_dev.depth}, 32'h0000_0000);
      cmd(ADDR_SHIFT, 32'h0000_0000);
      cmd(ADDR_DEPTH, 32'h0000_0001);
      cmp({24'h0, i_dev.depth}, 32'h0000_0001);
      cmd(ADDR_SHIFT, 32'h0000_0003);
      cmp({24'h0, i_dev.shift}, 32'h0000_0000);
      cmd(ADDR_DEPTH, 32'h0000_0002);
      cmp({24'h0, i_dev.depth}, 32'h0000_0002);
      cmd(ADDR_DEPTH, 32'h0000_0003);
      cmp({24'h0, i_dev.depth}, 32'h0000_0000);
      wr(ADDR_CFG, 32'h0000_0001);
      cmd(ADDR_SHIFT, 32'h0000_0004);
      cmp({24'h0, i_dev.shift}, 32'h0000_0000);
      cmd(ADDR_DEPTH, 32'h0000_0001);
      cmp({24'h0, i_dev.depth}, 32'h0000_0000);
      cmp({16'h0, i_dev.cursor}, 32'h0000_1234 + 32'(PITCH));
   endtask
   // Second cursor write lands mid-sequence and must leave no trace
   task automatic t_busy_drop();
      wr(ADDR_CURSOR, 32'h0000_5678);
      cmd(ADDR_CURSOR, 32'h0000_ABCD);
      cmp({16'h0, i_dev.cursor}, 32'h0000_5678);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_cgbase();
      t_cursor();
      t_shift_depth();
      t_busy_drop();
      report_and_stop();
   end
   // Whole run needs under a thousand cycles; this only cuts a hang
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         report_and_stop();
      end
   end
endmodule

// ===== ldc_pkg.sv
// Package for the display drawing-control host controller
package ldc_pkg;
   // Software register byte addresses
   localparam logic [7:0] ADDR_CGBASE = 8'h00;
   localparam logic [7:0] ADDR_SHIFT = 8'h04;
   localparam logic [7:0] ADDR_CURSOR = 8'h08;
   localparam logic [7:0] ADDR_DEPTH = 8'h0C;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CURRD = 8'h18;
   localparam logic [7:0] ADDR_FETCH = 8'h1C;
   localparam logic [7:0] ADDR_CHAR = 8'h20;
   localparam logic [7:0] ADDR_CHARADR = 8'h24;
   localparam logic [7:0] ADDR_CFG = 8'h28;
   // Device register map, reached only through indirect commands
   localparam logic [15:0] DEV_CGBASE_LO = 16'h8019;
   localparam logic [15:0] DEV_CGBASE_HI = 16'h801A;
   localparam logic [15:0] DEV_SHIFT = 16'h801B;
   localparam logic [15:0] DEV_CURSET_LO = 16'h801C;
   localparam logic [15:0] DEV_CURSET_HI = 16'h801D;
   localparam logic [15:0] DEV_CURGET_LO = 16'h801E;
   localparam logic [15:0] DEV_CURGET_HI = 16'h801F;
   localparam logic [15:0] DEV_DEPTH = 16'h8020;
   // Command bytes
   localparam logic [7:0] CMD_CGBASE = 8'h5C;
   localparam logic [7:0] CMD_SHIFT = 8'h5A;
   localparam logic [7:0] CMD_CURSOR_SET = 8'h46;
   localparam logic [7:0] CMD_CURSOR_GET = 8'h47;
   localparam logic [7:0] CMD_STORE = 8'h42;
   localparam logic [7:0] CMD_FETCH = 8'h43;
   localparam logic [7:0] CMD_DIR_BASE = 8'h4C;
   localparam logic [7:0] CMD_DEPTH = 8'h60;
   // Field positions and values
   localparam int OP_LSB = 0;
   localparam int DIR_LSB = 8;
   localparam int DATA_LSB = 8;
   localparam int HEIGHT_LSB = 8;
   localparam logic [1:0] OP_GET = 2'b00;
   localparam logic [1:0] OP_STORE = 2'b01;
   localparam logic [1:0] OP_FETCH = 2'b10;
   localparam logic [1:0] OP_DIR = 2'b11;
   localparam logic [1:0] DEPTH_1BPP = 2'b00;
   localparam logic [1:0] DEPTH_RSVD = 2'b11;
   localparam int CFG_USER_CHAR = 0;
   localparam int CFG_ROW_PAD = 1;
   // Timing
   localparam int CLK_NS = 20;
   localparam int STROBE_NS = 80;
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {
      XF_CMD = 2'b00,
      XF_PWR = 2'b01,
      XF_RD = 2'b10
   } ldc_xfer_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_HOLD = 2'b11
   } ldc_state_e;
   typedef struct packed {
      logic cs_n;
      logic a0;
      logic wr_n;
      logic rd_n;
      logic d_oe;
      logic [7:0] d;
   } ldc_pins_s;
endpackage
